// ===== smd_device.sv
module smd_device #(
    parameter int LATENCY = smd_pkg::SMD_DEF_LATENCY
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    smd_link_if.device link,
    input wire logic [7:0] nv_config_one,
    input wire logic [7:0] nv_config_three,
    output logic layout_uniform,
    output logic param_sectors_top
);
    import smd_pkg::*;

    // Refuse latencies the frame counter cannot hold
    if (LATENCY < 1 || LATENCY > 64)
    begin
        $error("LATENCY out of range");
    end

    typedef struct packed {
        logic sck_s1;
        logic sck_s2;
        logic sck_d;
        logic cs_s1;
        logic cs_s2;
        logic mosi_s1;
        logic mosi_s2;
        logic [8:0] cnt;
        logic [7:0] cmd;
        logic [31:0] addr;
        logic [7:0] osr;
        logic miso;
        logic uniform;
        logic top;
    } smd_dev_type;

    smd_dev_type st_r;
    smd_dev_type st_nxt;

    // ============================================================
    // Register file behind read any register
    // Architecture byte at four
    function automatic logic [7:0] reg_byte(input logic [31:0] a, input logic [7:0] one, input logic [7:0] three);
        if (a == SMD_NV_ONE_ADDR)
            return one;
        else if (a == SMD_NV_THREE_ADDR)
            return three;
        else
            return SMD_ZERO_BYTE;
    endfunction

    // ============================================================
    // Frame decoding and data return
    always_comb
    begin
        logic rise;
        logic fall;
        logic known;
        logic [8:0] alen;
        logic [8:0] hdr;
        logic [7:0] b;
        st_nxt = st_r;
        st_nxt.sck_s1 = link.sck;
        st_nxt.sck_s2 = st_r.sck_s1;
        st_nxt.sck_d = st_r.sck_s2;
        st_nxt.cs_s1 = link.cs_n;
        st_nxt.cs_s2 = st_r.cs_s1;
        st_nxt.mosi_s1 = link.mosi;
        st_nxt.mosi_s2 = st_r.mosi_s1;
        rise = st_r.sck_s2 && !st_r.sck_d;
        fall = !st_r.sck_s2 && st_r.sck_d;
        known = (st_r.cmd == SMD_CMD_TABLE_READ) || (st_r.cmd == SMD_CMD_READ_ANY_REG);
        // Address length follows the command
        alen = (st_r.cmd == SMD_CMD_TABLE_READ) ? 9'(SMD_TABLE_ADDR_BITS) : 9'(SMD_REG_ADDR_BITS);
        hdr = (st_r.cmd == SMD_CMD_TABLE_READ) ? 9'(SMD_CMD_BITS + SMD_TABLE_ADDR_BITS + SMD_TABLE_DUMMY)
            : 9'(SMD_CMD_BITS + SMD_REG_ADDR_BITS + LATENCY);
        b = SMD_ZERO_BYTE;
        if (st_r.cs_s2)
        begin
            // Deselected: frame state cleared, line parked low
            st_nxt.cnt = '0;
            st_nxt.cmd = '0;
            st_nxt.addr = '0;
            st_nxt.miso = 1'b0;
        end
        else if (rise)
        begin
            st_nxt.cnt = st_r.cnt + 9'd1;
            if (st_r.cnt < 9'(SMD_CMD_BITS))
                st_nxt.cmd = {st_r.cmd[6:0], st_r.mosi_s2};
            else if (st_r.cnt < 9'(SMD_CMD_BITS) + alen)
                st_nxt.addr = {st_r.addr[30:0], st_r.mosi_s2};
        end
        else if (fall && known && st_r.cnt >= hdr)
        begin
            if (st_r.cnt[2:0] == hdr[2:0])
            begin
                if (st_r.cmd == SMD_CMD_TABLE_READ)
                    b = smd_table_byte(st_r.addr);
                else
                    b = reg_byte(st_r.addr, nv_config_one, nv_config_three);
                st_nxt.miso = b[7];
                st_nxt.osr = {b[6:0], 1'b0};
                st_nxt.addr = st_r.addr + 32'd1;
            end
            else
            begin
                st_nxt.miso = st_r.osr[7];
                st_nxt.osr = {st_r.osr[6:0], 1'b0};
            end
        end
        st_nxt.uniform = nv_config_three[SMD_ARCH_BIT];
        st_nxt.top = nv_config_one[SMD_LOC_BIT];
    end

    // Synchronous reset; sck and cs sampled idle-safe
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            st_r <= '0;
            st_r.cs_s1 <= 1'b1;
            st_r.cs_s2 <= 1'b1;
        end
        else
            st_r <= st_nxt;
    end

    assign link.miso = st_r.miso;
    assign layout_uniform = st_r.uniform;
    assign param_sectors_top = st_r.top;
endmodule

// ===== smd_host.sv
module smd_host #(
    parameter int DIV = 8,
    parameter int LATENCY = smd_pkg::SMD_DEF_LATENCY
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    smd_link_if.host link,
    input wire logic start,
    output logic busy,
    output logic done,
    output logic map_error,
    output logic [7:0] map_index,
    output logic [7:0] erase_type1_op,
    output logic [7:0] erase_type2_op,
    output logic [7:0] erase_type3_op,
    output logic [7:0] erase_type4_op
);
    import smd_pkg::*;

    // Device return path needs about five cycles of a half period
    if (DIV < 8 || DIV > 255)
    begin
        $error("DIV out of range");
    end
    // Header and dummy must fit the 64-bit transmit shift register
    if (LATENCY < 1 || LATENCY > 24)
    begin
        $error("LATENCY out of range");
    end

    typedef enum logic [1:0] {
        H_IDLE = 2'b00,
        H_XFER = 2'b01,
        H_EVAL = 2'b11,
        H_FIN = 2'b10
    } smd_hstate_type;

    typedef struct packed {
        smd_hstate_type state;
        logic [1:0] stage;
        logic [7:0] div;
        logic miso_s1;
        logic miso_s2;
        logic sck;
        logic cs_n;
        logic mosi;
        logic [63:0] tx;
        logic [8:0] cnt;
        logic [8:0] hdr;
        logic [8:0] total;
        logic [7:0] rx;
        logic [SMD_TABLE_BYTES-1:0][7:0] tbl;
        logic arch;
        logic loc;
        logic done;
        logic err;
        logic [7:0] index;
    } smd_host_type;

    smd_host_type st_r;
    smd_host_type st_nxt;

    // ============================================================
    // Sequencer and serial engine
    always_comb
    begin
        logic tick;
        logic [8:0] k;
        logic [7:0] mask;
        logic [7:0] idx;
        tick = (st_r.div == 8'(DIV - 1));
        k = '0;
        mask = '0;
        idx = '0;
        st_nxt = st_r;
        st_nxt.done = 1'b0;
        st_nxt.miso_s1 = link.miso;
        st_nxt.miso_s2 = st_r.miso_s1;
        st_nxt.div = (tick || st_r.state != H_XFER) ? 8'd0 : st_r.div + 8'd1;
        unique case (st_r.state)
            H_IDLE:
            begin
                if (start)
                begin
                    // Table read from the erase dword through both descriptors
                    st_nxt.stage = 2'd0;
                    st_nxt.err = 1'b0;
                    st_nxt.tx = {SMD_CMD_TABLE_READ, SMD_TABLE_BASE[23:0], 32'h0};
                    st_nxt.mosi = SMD_CMD_TABLE_READ[7];
                    st_nxt.hdr = 9'(SMD_CMD_BITS + SMD_TABLE_ADDR_BITS + SMD_TABLE_DUMMY);
                    st_nxt.total = 9'(SMD_CMD_BITS + SMD_TABLE_ADDR_BITS + SMD_TABLE_DUMMY + 8 * SMD_TABLE_BYTES);
                    st_nxt.cnt = '0;
                    st_nxt.cs_n = 1'b0;
                    st_nxt.state = H_XFER;
                end
            end
            H_XFER:
            begin
                if (tick && !st_r.sck)
                begin
                    // Rising edge: device samples, host captures
                    st_nxt.sck = 1'b1;
                    st_nxt.cnt = st_r.cnt + 9'd1;
                    if (st_r.cnt >= st_r.hdr)
                    begin
                        k = st_r.cnt - st_r.hdr;
                        st_nxt.rx = {st_r.rx[6:0], st_r.miso_s2};
                        if (k[2:0] == 3'd7 && st_r.stage == 2'd0)
                            st_nxt.tbl[k[7:3]] = {st_r.rx[6:0], st_r.miso_s2};
                    end
                end
                else if (tick)
                begin
                    st_nxt.sck = 1'b0;
                    st_nxt.tx = {st_r.tx[62:0], 1'b0};
                    st_nxt.mosi = st_r.tx[62];
                    if (st_r.cnt == st_r.total)
                    begin
                        st_nxt.cs_n = 1'b1;
                        st_nxt.mosi = 1'b0;
                        st_nxt.state = H_EVAL;
                    end
                end
            end
            H_EVAL:
            begin
                mask = (st_r.stage == 2'd1) ? st_r.tbl[SMD_POS_DET1 + SMD_DESC_MASK]
                    : st_r.tbl[SMD_POS_DET2 + SMD_DESC_MASK];
                if (st_r.stage == 2'd1)
                    st_nxt.arch = |(st_r.rx & mask);
                if (st_r.stage == 2'd2)
                    st_nxt.loc = |(st_r.rx & mask);
                st_nxt.cnt = '0;
                st_nxt.hdr = 9'(SMD_CMD_BITS + SMD_REG_ADDR_BITS + LATENCY);
                st_nxt.total = 9'(SMD_CMD_BITS + SMD_REG_ADDR_BITS + LATENCY + 8);
                if (st_r.stage == 2'd0)
                begin
                    if (st_r.tbl[SMD_POS_DET1][SMD_DESC_KIND_BIT] || st_r.tbl[SMD_POS_DET2][SMD_DESC_KIND_BIT])
                    begin
                        st_nxt.err = 1'b1;
                        st_nxt.state = H_FIN;
                    end
                    else
                    begin
                        // Detection instruction and address from table
                        st_nxt.tx = {st_r.tbl[SMD_POS_DET1 + SMD_DESC_INSTR], st_r.tbl[SMD_POS_DET1_ADDR + 3],
                            st_r.tbl[SMD_POS_DET1_ADDR + 2], st_r.tbl[SMD_POS_DET1_ADDR + 1],
                            st_r.tbl[SMD_POS_DET1_ADDR], 24'h0};
                        st_nxt.mosi = st_r.tbl[SMD_POS_DET1 + SMD_DESC_INSTR][7];
                        st_nxt.stage = 2'd1;
                        st_nxt.cs_n = 1'b0;
                        st_nxt.state = H_XFER;
                    end
                end
                else if (st_r.stage == 2'd1)
                begin
                    st_nxt.tx = {st_r.tbl[SMD_POS_DET2 + SMD_DESC_INSTR], st_r.tbl[SMD_POS_DET2_ADDR + 3],
                        st_r.tbl[SMD_POS_DET2_ADDR + 2], st_r.tbl[SMD_POS_DET2_ADDR + 1],
                        st_r.tbl[SMD_POS_DET2_ADDR], 24'h0};
                    st_nxt.mosi = st_r.tbl[SMD_POS_DET2 + SMD_DESC_INSTR][7];
                    st_nxt.stage = 2'd2;
                    st_nxt.cs_n = 1'b0;
                    st_nxt.state = H_XFER;
                end
                else
                    st_nxt.state = H_FIN;
            end
            H_FIN:
            begin
                idx = {5'b0, st_r.arch, st_r.loc, 1'b1};
                st_nxt.index = idx;
                if (idx != SMD_IDX_HYB_BOTTOM && idx != SMD_IDX_HYB_TOP && idx != SMD_IDX_UNIFORM)
                    st_nxt.err = 1'b1;
                st_nxt.done = 1'b1;
                st_nxt.state = H_IDLE;
            end
        endcase
    end

    // Synchronous reset, link idle with select high
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            st_r <= '0;
            st_r.state <= H_IDLE;
            st_r.cs_n <= 1'b1;
        end
        else
            st_r <= st_nxt;
    end

    assign link.sck = st_r.sck;
    assign link.cs_n = st_r.cs_n;
    assign link.mosi = st_r.mosi;
    assign busy = (st_r.state != H_IDLE);
    assign done = st_r.done;
    assign map_error = st_r.err;
    assign map_index = st_r.index;
    assign erase_type1_op = st_r.tbl[0];
    assign erase_type2_op = st_r.tbl[1];
    assign erase_type3_op = st_r.tbl[2];
    assign erase_type4_op = st_r.tbl[3];
endmodule

// ===== smd_link_if.sv
interface smd_link_if;
    logic sck;
    logic cs_n;
    logic mosi;
    logic miso;
    modport host (output sck, output cs_n, output mosi, input miso);
    modport device (input sck, input cs_n, input mosi, output miso);
endinterface

// ===== smd_link_monitor.sv
module smd_link_monitor #(
    parameter int DIV = 8
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic sck,
    input wire logic cs_n,
    input wire logic mosi,
    input wire logic miso
);
    timeunit 1ns;
    timeprecision 1ps;
    logic sck_q;
    logic [8:0] rise_cnt;
    logic [31:0] sr;
    logic [7:0] cmd_q;
    int run_cnt;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    // ============================================================
    // Frame tracking
    // Rises counted per frame; shift register mirrors what the device samples
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            sck_q <= 1'b0;
            run_cnt <= 0;
            rise_cnt <= 9'h0;
            sr <= 32'h0;
            cmd_q <= 8'h0;
        end
        else
        begin
            sck_q <= sck;
            run_cnt <= (sck != sck_q) ? 0 : run_cnt + 1;
            if (cs_n)
                rise_cnt <= 9'h0;
            else if (sck && !sck_q)
            begin
                rise_cnt <= rise_cnt + 9'h1;
                sr <= {sr[30:0], mosi};
                if (rise_cnt == 9'h7)
                    cmd_q <= {sr[6:0], mosi};
            end
        end
    end
    // ============================================================
    // Link checks
    sel_idle_a: assert property (cs_n |-> !sck)
        else $error("serial clock active while deselected");
    frame_open_a: assert property ($fell(cs_n) |-> !mosi && !sck)
        else $error("frame opened with wrong first bit");
    half_period_a: assert property ($fell(sck) && !cs_n |-> run_cnt == DIV - 1)
        else $error("serial clock high time wrong");
    mosi_hold_a: assert property (sck && $past(sck) |-> $stable(mosi))
        else $error("host data moved while clock high");
    miso_hold_a: assert property (sck && $past(sck) && !cs_n |-> $stable(miso))
        else $error("device data moved while clock high");
    cmd_code_a: assert property (rise_cnt == 9'h8 && $past(rise_cnt) == 9'h7 |-> cmd_q inside {8'h5a, 8'h65})
        else $error("unexpected command code");
    reg_addr_a: assert property (rise_cnt == 9'd40 && cmd_q == 8'h65 |-> sr inside {32'h4, 32'h2})
        else $error("register address not a detection address");
    table_len_a: assert property ($rose(cs_n) && cmd_q == 8'h5a |-> rise_cnt == 9'd200)
        else $error("table frame length wrong");
endmodule

// ===== smd_pkg.sv
package smd_pkg;
    // ============================================================
    // Link commands and framing
    localparam logic [7:0] SMD_CMD_TABLE_READ = 8'h5a;
    localparam logic [7:0] SMD_CMD_READ_ANY_REG = 8'h65;
    localparam int SMD_CMD_BITS = 8;
    localparam int SMD_TABLE_ADDR_BITS = 24;
    localparam int SMD_REG_ADDR_BITS = 32;
    localparam int SMD_TABLE_DUMMY = 8;
    localparam int SMD_DEF_LATENCY = 8;
    // ============================================================
    // Discoverable table content
    localparam logic [31:0] SMD_TABLE_BASE = 32'h0000_0044;
    localparam int SMD_TABLE_BYTES = 20;
    localparam logic [31:0] SMD_ERASE_DWORD = 32'hff_dc_dc_21;
    localparam logic [31:0] SMD_DETECT1_DWORD = 32'h08_ff_65_fc;
    localparam logic [31:0] SMD_DETECT1_ADDR = 32'h0000_0004;
    localparam logic [31:0] SMD_DETECT2_DWORD = 32'h04_ff_65_fc;
    localparam logic [31:0] SMD_DETECT2_ADDR = 32'h0000_0002;
    localparam logic [7:0] SMD_BLANK_BYTE = 8'hff;
    localparam logic [7:0] SMD_ZERO_BYTE = 8'h00;
    // Byte positions within the host copy of the table
    localparam int SMD_POS_DET1 = 4;
    localparam int SMD_POS_DET1_ADDR = 8;
    localparam int SMD_POS_DET2 = 12;
    localparam int SMD_POS_DET2_ADDR = 16;
    localparam int SMD_DESC_INSTR = 1;
    localparam int SMD_DESC_MASK = 3;
    localparam int SMD_DESC_KIND_BIT = 1;
    // ============================================================
    // Configuration registers and map indexes
    localparam logic [31:0] SMD_NV_ONE_ADDR = 32'h0000_0002;
    localparam logic [31:0] SMD_NV_THREE_ADDR = 32'h0000_0004;
    localparam int SMD_ARCH_BIT = 3;
    localparam int SMD_LOC_BIT = 2;
    localparam logic [7:0] SMD_IDX_HYB_BOTTOM = 8'h01;
    localparam logic [7:0] SMD_IDX_HYB_TOP = 8'h03;
    localparam logic [7:0] SMD_IDX_UNIFORM = 8'h05;

    // Table byte at a relative offset, dwords least significant byte first
    function automatic logic [7:0] smd_table_byte(input logic [31:0] addr);
        logic [31:0] rel;
        logic [31:0] dw;
        rel = addr - SMD_TABLE_BASE;
        unique case (rel[31:2])
            30'h0: dw = SMD_ERASE_DWORD;
            30'h1: dw = SMD_DETECT1_DWORD;
            30'h2: dw = SMD_DETECT1_ADDR;
            30'h3: dw = SMD_DETECT2_DWORD;
            30'h4: dw = SMD_DETECT2_ADDR;
            default: dw = {4{SMD_BLANK_BYTE}};
        endcase
        return dw[rel[1:0]*8 +: 8];
    endfunction
endpackage

// ===== tb_sector_map_discovery_table.sv
module tb_sector_map_discovery_table;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk;
    logic rst_n;
    logic start;
    logic [7:0] nv_config_one;
    logic [7:0] nv_config_three;
    logic busy, done, map_error, layout_uniform, param_sectors_top;
    logic [7:0] map_index, op1, op2, op3, op4;
    int err_count;
    int cmp_count;
    int seed;
    int frame_no;
    int nbits;
    logic [31:0] r;
    logic [7:0] cmd_in;
    logic [31:0] addr_in;
    logic [159:0] data_in;

    smd_link_if link_if ();
    smd_device #(.LATENCY(8)) smd_device_inst (.ref_clk(ref_clk), .rst_n(rst_n), .link(link_if),
        .nv_config_one(nv_config_one), .nv_config_three(nv_config_three),
        .layout_uniform(layout_uniform), .param_sectors_top(param_sectors_top));
    smd_host #(.DIV(8), .LATENCY(8)) smd_host_inst (.ref_clk(ref_clk), .rst_n(rst_n), .link(link_if),
        .start(start), .busy(busy), .done(done), .map_error(map_error), .map_index(map_index),
        .erase_type1_op(op1), .erase_type2_op(op2), .erase_type3_op(op3), .erase_type4_op(op4));
    smd_link_monitor #(.DIV(8)) smd_link_monitor_inst (.ref_clk(ref_clk), .rst_n(rst_n),
        .sck(link_if.sck), .cs_n(link_if.cs_n), .mosi(link_if.mosi), .miso(link_if.miso));

    // ============================================================
    // Expectations
    function automatic logic [31:0] lsb_first(input logic [31:0] dw);
        return {dw[7:0], dw[15:8], dw[23:16], dw[31:24]};
    endfunction
    // Command descriptor: mask, variable length and latency, all-ones spare bits
    function automatic logic [31:0] descriptor(input logic [7:0] mask);
        return {mask, 2'b11, 2'b11, 4'b1111, 8'h65, 6'b111111, 1'b0, 1'b0};
    endfunction
    function automatic logic [159:0] table_exp();
        return {lsb_first(32'hff_dc_dc_21), lsb_first(descriptor(8'h08)), lsb_first(32'h4),
            lsb_first(descriptor(8'h04)), lsb_first(32'h2)};
    endfunction
    // Map index per configuration; the unsupported pairing reads as 07h
    function automatic logic [7:0] exp_index(input logic arch, input logic loc);
        case ({arch, loc})
            2'b00: return 8'h01;
            2'b01: return 8'h03;
            2'b10: return 8'h05;
            default: return 8'h07;
        endcase
    endfunction

    task automatic check(input logic [159:0] got, input logic [159:0] exp, input string what);
        cmp_count++;
        if (got !== exp)
        begin
            err_count++;
            $display("MISMATCH at %0t: %s got %0h expected %0h", $time, what, got, exp);
        end
    endtask

    task automatic finish_test();
        $display("comparisons %0d, mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // ============================================================
    // Wire watcher, rebuilt from the link alone
    always @(negedge link_if.cs_n)
    begin
        nbits = 0;
        frame_no++;
    end
    always @(posedge link_if.sck)
    begin
        if (nbits < 8)
            cmd_in = {cmd_in[6:0], link_if.mosi};
        else if (nbits < 40)
            addr_in = {addr_in[30:0], link_if.mosi};
        data_in = {data_in[158:0], link_if.miso};
        nbits++;
    end
    // Frame order is fixed: table, then architecture byte, then location byte
    always @(posedge link_if.cs_n)
    begin
        if (rst_n === 1'b1)
        begin
            check(cmd_in, (frame_no == 1) ? 8'h5a : 8'h65, "command");
            if (frame_no == 1)
                check(data_in, table_exp(), "table bytes");
            else
            begin
                check(addr_in, (frame_no == 2) ? 32'h4 : 32'h2, "register address");
                check(data_in[7:0], (frame_no == 2) ? nv_config_three : nv_config_one, "register byte");
            end
        end
    end

    // ============================================================
    // One discovery run; a long start pulse must be taken only once
    task automatic run_case(input logic arch, input logic loc, input int hold);
        logic [31:0] v;
        int n;
        v = $random(seed);
        @(negedge ref_clk);
        nv_config_one = {v[7:3], loc, v[1:0]};
        nv_config_three = {v[15:12], arch, v[10:8]};
        frame_no = 0;
        start = 1'b1;
        repeat (hold) @(negedge ref_clk);
        start = 1'b0;
        check(busy, 1'b1, "busy after start");
        n = 0;
        while (done !== 1'b1 && n < 20000)
        begin
            @(negedge ref_clk);
            n++;
        end
        check(n < 20000, 1'b1, "completion");
        check(frame_no, 3, "frame count");
        check(map_index, exp_index(arch, loc), "map index");
        check(map_error, arch & loc, "map error");
        check({op4, op3, op2, op1}, 32'hff_dc_dc_21, "erase codes");
        check(layout_uniform, arch, "uniform layout");
        check(param_sectors_top, loc, "sectors top");
        @(negedge ref_clk);
        check(busy, 1'b0, "busy after done");
        check(done, 1'b0, "done one cycle");
        $display("test arch=%0b loc=%0b ended, mismatches %0d", arch, loc, err_count);
    endtask

    // ============================================================
    // Clock, sequence and watchdog
    initial
    begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end
    initial
    begin
        seed = 32'h8e5d;
        err_count = 0;
        cmp_count = 0;
        rst_n = 1'b0;
        start = 1'b0;
        nv_config_one = 8'h00;
        nv_config_three = 8'h00;
        frame_no = 0;
        nbits = 0;
        repeat (16) @(negedge ref_clk);
        check({link_if.cs_n, link_if.sck, link_if.mosi, link_if.miso, busy, done, map_error, map_index},
            15'h4000, "reset state");
        check({op4, op3, op2, op1, layout_uniform, param_sectors_top}, 34'h0, "reset outputs");
        rst_n = 1'b1;
        repeat (4) @(negedge ref_clk);
        // Four corners first, then random picks
        for (int i = 0; i < 8; i++)
        begin
            r = $random(seed);
            run_case((i < 4) ? i[1] : r[1], (i < 4) ? i[0] : r[0], (i == 2) ? 5 : 1);
        end
        finish_test();
    end
    // Eight runs need about 40k cycles; this allows nearly twice that
    initial
    begin
        #300000;
        err_count++;
        $display("MISMATCH at %0t: run did not finish", $time);
        finish_test();
    end
endmodule
